//--- snl_addr_check.sv
`timescale 1ns/1ps
`include "snl_defines.svh"
module snl_addr_check (
  input  wire logic [`SNL_COL_W-1:0] columnAddress,
  input  wire logic [`SNL_ROW_W-1:0] rowAddress,
  input  wire logic                  eccEnable,
  output logic                       colValid,
  output logic                       colWritable,
  output logic [`SNL_PAGE_MSB:0]     pageSel,
  output logic [`SNL_BLK_MSB-`SNL_BLK_LSB:0] blockSel
);
  assign colValid    = columnAddress <= `SNL_COL_LAST;
  // upper spare half holds ecc parity while ecc is on
  assign colWritable = colValid &&
    (!eccEnable || columnAddress < `SNL_SPARE_WR);
  assign pageSel  = rowAddress[`SNL_PAGE_MSB:0];
  assign blockSel = rowAddress[`SNL_BLK_MSB:`SNL_BLK_LSB];
endmodule : snl_addr_check

//--- snl_defines.svh
`ifndef SNL_DEFINES_SVH
`define SNL_DEFINES_SVH

// column map, byte offsets inside one page
`define SNL_COL_W       12
`define SNL_COL_LAST    12'h87f
`define SNL_SPARE_BASE  12'h800
`define SNL_SPARE_WR    12'h840

// row map
`define SNL_ROW_W       18
`define SNL_PAGE_MSB    5
`define SNL_BLK_LSB     6
`define SNL_BLK_MSB     17

// slices per byte minus one, per lane mode
`define SNL_LAST_X1     3'h7
`define SNL_LAST_X2     3'h3
`define SNL_LAST_X4     3'h1

// protect bits {complement, range invert, bp2, bp1, bp0}
`define SNL_PROT_W      5
`define SNL_PROT_RST    5'h00

// pin synchroniser: {csB, sclk, lane3..lane0}
`define SNL_SYNC_W      6
`define SNL_SYNC_RST    6'h2c

`endif

//--- snl_host_model.sv
`timescale 1ns/1ps
module snl_host_model (
  input  wire logic       clk,
  input  wire logic       pin1,
  output logic            csB,
  output logic            sclk,
  output logic [3:0]      lane
);
  initial begin
    csB  = 1'h1;
    sclk = 1'h0;
    lane = 4'hc;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic clkTo(input logic v);
    sclk <= v;
    cyc(8);
  endtask : clkTo

  task automatic setLane(input int k, input logic v);
    lane[k] <= v;
    cyc(8);
  endtask : setLane

  // idle level chosen before select so the first edge is never a glitch
  task automatic sel(input logic m3);
    sclk    <= m3;
    lane[3] <= 1'h1;
    cyc(8);
    csB <= 1'h0;
    cyc(8);
  endtask : sel

  task automatic desel(input logic m3);
    sclk <= m3;
    cyc(8);
    csB <= 1'h1;
    cyc(8);
  endtask : desel

  // data moves with sclk low, half period of 8 clk gives 32 ns
  task automatic xfer(input logic [7:0] b, input int w, input int f,
                      input int l, output logic [7:0] got);
    logic [3:0] m;
    logic [7:0] s;
    m   = 4'((1 << w) - 1);
    got = 8'h00;
    for (int i = f; i <= l; i++) begin
      s = b >> (8 - w * (i + 1));
      sclk <= 1'h0;
      lane <= (lane & ~m) | (s[3:0] & m);
      cyc(8);
      got = {got[6:0], pin1};
      sclk <= 1'h1;
      cyc(8);
    end
  endtask : xfer
endmodule : snl_host_model

//--- snl_link.sv
// Behaviour
// - only clock modes 0 and 3 supported
// - sample on sclk rise, shift on fall
// - idle whenever chip select is high
// - dual mode uses lanes 0 and 1
// - quad mode adds protect and pause lanes
// - dtr quad output changes on both edges
// - dtr quad needs quad enable set
// - pause works only with quad enable clear
// - pause stops link, not array operations
// - pause starts on pause low, sclk low
// - pause ends on pause high, sclk low
// - paused: output tristate, input and sclk ignored
// - deselect while paused resets interface
// - lock plus protect pin low refuses changes
// - protect pin effective only without quad enable
// - column is 12 bits, valid to 2175
// - row low six bits page, rest block
// - ecc on: upper 64 spare bytes unwritable
// - ecc off: all 128 spare bytes writable
`timescale 1ns/1ps
`include "snl_defines.svh"
module snl_link
  import snl_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  csB,
  input  wire logic                  sclk,
  input  wire logic                  ioLane0In,
  input  wire logic                  ioLane1In,
  input  wire logic                  ioLane2In,
  input  wire logic                  ioLane3In,
  output logic                       ioLane0Out,
  output logic                       ioLane1Out,
  output logic                       ioLane2Out,
  output logic                       ioLane3Out,
  output logic                       ioLane0Oe,
  output logic                       ioLane1Oe,
  output logic                       ioLane2Oe,
  output logic                       ioLane3Oe,
  input  wire logic                  quadEnableBit,
  input  snl_lane_t                  laneMode,
  input  wire logic                  txEn,
  input  wire logic [7:0]            txByte,
  output logic                       txTake,
  output logic [7:0]                 rxByte,
  output logic                       rxValid,
  output logic                       clkMode3,
  output logic                       linkIdle,
  output logic                       linkPaused,
  output logic                       dtrReject,
  input  wire logic                  protectBitsLock,
  input  wire logic                  protWrReq,
  input  wire logic [`SNL_PROT_W-1:0] protWrData,
  output logic [`SNL_PROT_W-1:0]     protBits,
  output logic                       protRefused,
  input  wire logic                  eccEnable,
  input  wire logic [`SNL_COL_W-1:0] columnAddress,
  input  wire logic [`SNL_ROW_W-1:0] rowAddress,
  output logic                       colValid,
  output logic                       colWritable,
  output logic [`SNL_PAGE_MSB:0]     pageSel,
  output logic [`SNL_BLK_MSB-`SNL_BLK_LSB:0] blockSel
);

  function automatic logic [2:0] lastSlice(snl_lane_t m);
    unique case (m)
      LANE_X1:     lastSlice = `SNL_LAST_X1;
      LANE_X2:     lastSlice = `SNL_LAST_X2;
      LANE_X4:     lastSlice = `SNL_LAST_X4;
      LANE_X4_DTR: lastSlice = `SNL_LAST_X4;
    endcase
  endfunction : lastSlice

  logic [`SNL_SYNC_W-1:0] syncQ;
  logic       csS;
  logic       sclkS;
  logic [3:0] lanesS;
  logic       sclkPrev_r;
  logic       sclkRise;
  logic       sclkFall;
  snl_lane_t  effMode;
  logic       pauseOk;
  logic       holdLevel;
  logic       hwLocked;

  snl_sync #(.W(`SNL_SYNC_W), .RST(`SNL_SYNC_RST)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({csB, sclk, ioLane3In, ioLane2In, ioLane1In, ioLane0In}),
    .q     (syncQ)
  );

  assign csS       = syncQ[5];
  assign sclkS     = syncQ[4];
  assign lanesS    = syncQ[3:0];
  assign sclkRise  = sclkS && !sclkPrev_r;
  assign sclkFall  = !sclkS && sclkPrev_r;
  assign holdLevel = lanesS[3];
  assign pauseOk   = !quadEnableBit;
  // with quad enable set the protect pin is plain data
  assign hwLocked  = protectBitsLock && !lanesS[2] &&
                     !quadEnableBit;
  // refused dtr falls back to single lane
  assign effMode = (laneMode == LANE_X4_DTR && !quadEnableBit) ?
                   LANE_X1 : laneMode;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclkPrev_r <= 1'h0;
    end else begin
      sclkPrev_r <= sclkS;
    end
  end

  // link state
  snl_state_t state_r;
  snl_state_t state_nxt;
  logic       mode3_r;
  logic       mode3_nxt;
  logic       dtrRej_r;
  logic       dtrRej_nxt;

  always_comb begin
    state_nxt  = state_r;
    mode3_nxt  = mode3_r;
    dtrRej_nxt = laneMode == LANE_X4_DTR && !quadEnableBit;
    unique case (state_r)
      ST_IDLE: begin
        // rest level of sclk at select tells mode 0 from 3
        if (!csS) begin
          state_nxt = ST_ACTIVE;
          mode3_nxt = sclkS;
        end
      end
      ST_ACTIVE: begin
        if (csS) begin
          state_nxt = ST_IDLE;
        end else if (pauseOk && !holdLevel && !sclkS) begin
          state_nxt = ST_PAUSED;
        end
      end
      ST_PAUSED: begin
        if (csS) begin
          state_nxt = ST_IDLE;
        end else if (!pauseOk || (holdLevel && !sclkS)) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r  <= ST_IDLE;
      mode3_r  <= 1'h0;
      dtrRej_r <= 1'h0;
    end else begin
      state_r  <= state_nxt;
      mode3_r  <= mode3_nxt;
      dtrRej_r <= dtrRej_nxt;
    end
  end

  // receive shifter; rx counter freezes while paused
  logic       rxEdge;
  logic [7:0] rxSh_r;
  logic [7:0] rxSh_nxt;
  logic [2:0] rxCnt_r;
  logic [2:0] rxCnt_nxt;
  logic [7:0] rxByte_r;
  logic [7:0] rxByte_nxt;
  logic       rxValid_r;
  logic       rxValid_nxt;
  logic       txOn_r;

  assign rxEdge = state_r == ST_ACTIVE && sclkRise &&
                  !txOn_r;

  always_comb begin
    rxSh_nxt    = rxSh_r;
    rxCnt_nxt   = rxCnt_r;
    rxByte_nxt  = rxByte_r;
    rxValid_nxt = 1'h0;
    if (csS) begin
      rxCnt_nxt = 3'h0;
    end else if (rxEdge) begin
      unique case (effMode)
        LANE_X1: rxSh_nxt = {rxSh_r[6:0], lanesS[0]};
        LANE_X2: rxSh_nxt = {rxSh_r[5:0], lanesS[1:0]};
        LANE_X4, LANE_X4_DTR:
          rxSh_nxt = {rxSh_r[3:0], lanesS};
      endcase
      if (rxCnt_r == lastSlice(effMode)) begin
        rxCnt_nxt   = 3'h0;
        rxByte_nxt  = rxSh_nxt;
        rxValid_nxt = 1'h1;
      end else begin
        rxCnt_nxt = rxCnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxSh_r    <= 8'h00;
      rxCnt_r   <= 3'h0;
      rxByte_r  <= 8'h00;
      rxValid_r <= 1'h0;
    end else begin
      rxSh_r    <= rxSh_nxt;
      rxCnt_r   <= rxCnt_nxt;
      rxByte_r  <= rxByte_nxt;
      rxValid_r <= rxValid_nxt;
    end
  end

  // transmit shifter
  logic       txEdge;
  logic       txOn_nxt;
  logic [7:0] txSh_r;
  logic [7:0] txSh_nxt;
  logic [2:0] txCnt_r;
  logic [2:0] txCnt_nxt;
  logic       txTake_r;
  logic       txTake_nxt;
  logic [3:0] laneOut_r;
  logic [3:0] laneOut_nxt;
  logic [3:0] laneOe;

  // dtr adds the rising edge once a byte is on the lanes
  assign txEdge = state_r == ST_ACTIVE && (sclkFall ||
    (effMode == LANE_X4_DTR && sclkRise && txOn_r));

  always_comb begin
    txOn_nxt   = txOn_r;
    txSh_nxt   = txSh_r;
    txCnt_nxt  = txCnt_r;
    txTake_nxt = 1'h0;
    if (csS || !txEn) begin
      txOn_nxt  = 1'h0;
      txCnt_nxt = 3'h0;
    end else if (txEdge) begin
      if (!txOn_r || txCnt_r == lastSlice(effMode)) begin
        txSh_nxt   = txByte;
        txCnt_nxt  = 3'h0;
        txOn_nxt   = 1'h1;
        txTake_nxt = 1'h1;
      end else begin
        txCnt_nxt = txCnt_r + 3'h1;
        unique case (effMode)
          LANE_X1: txSh_nxt = {txSh_r[6:0], 1'h0};
          LANE_X2: txSh_nxt = {txSh_r[5:0], 2'h0};
          LANE_X4, LANE_X4_DTR: txSh_nxt = {txSh_r[3:0], 4'h0};
        endcase
      end
    end
    unique case (effMode)
      LANE_X1: laneOut_nxt = {2'h0, txSh_nxt[7], 1'h0};
      LANE_X2: laneOut_nxt = {2'h0, txSh_nxt[7:6]};
      LANE_X4, LANE_X4_DTR:
        laneOut_nxt = txSh_nxt[7:4];
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txOn_r    <= 1'h0;
      txSh_r    <= 8'h00;
      txCnt_r   <= 3'h0;
      txTake_r  <= 1'h0;
      laneOut_r <= 4'h0;
    end else begin
      txOn_r    <= txOn_nxt;
      txSh_r    <= txSh_nxt;
      txCnt_r   <= txCnt_nxt;
      txTake_r  <= txTake_nxt;
      laneOut_r <= laneOut_nxt;
    end
  end

  // pause cuts the drivers and stops both shifters; the array side never sees it
  always_comb begin
    laneOe = 4'h0;
    if (state_r == ST_ACTIVE && txOn_r && !csS) begin
      unique case (effMode)
        LANE_X1: laneOe = 4'h2;
        LANE_X2: laneOe = 4'h3;
        LANE_X4, LANE_X4_DTR: laneOe = 4'hf;
      endcase
    end
  end

  // protect bits
  logic [`SNL_PROT_W-1:0] prot_r;
  logic [`SNL_PROT_W-1:0] prot_nxt;
  logic                   protRef_r;
  logic                   protRef_nxt;

  always_comb begin
    prot_nxt    = prot_r;
    protRef_nxt = 1'h0;
    if (protWrReq) begin
      if (hwLocked) begin
        protRef_nxt = 1'h1;
      end else begin
        prot_nxt = protWrData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prot_r    <= `SNL_PROT_RST;
      protRef_r <= 1'h0;
    end else begin
      prot_r    <= prot_nxt;
      protRef_r <= protRef_nxt;
    end
  end

  // address check, registered
  logic       colValid_nxt;
  logic       colWr_nxt;
  logic [`SNL_PAGE_MSB:0] page_nxt;
  logic [`SNL_BLK_MSB-`SNL_BLK_LSB:0] block_nxt;
  logic       colValid_r;
  logic       colWr_r;
  logic [`SNL_PAGE_MSB:0] page_r;
  logic [`SNL_BLK_MSB-`SNL_BLK_LSB:0] block_r;

  snl_addr_check u_addr (
    .columnAddress (columnAddress),
    .rowAddress    (rowAddress),
    .eccEnable     (eccEnable),
    .colValid      (colValid_nxt),
    .colWritable   (colWr_nxt),
    .pageSel       (page_nxt),
    .blockSel      (block_nxt)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      colValid_r <= 1'h0;
      colWr_r    <= 1'h0;
      page_r     <= '0;
      block_r    <= '0;
    end else begin
      colValid_r <= colValid_nxt;
      colWr_r    <= colWr_nxt;
      page_r     <= page_nxt;
      block_r    <= block_nxt;
    end
  end

  assign {ioLane3Out, ioLane2Out, ioLane1Out, ioLane0Out} = laneOut_r;
  assign {ioLane3Oe, ioLane2Oe, ioLane1Oe, ioLane0Oe}     = laneOe;
  assign txTake      = txTake_r;
  assign rxByte      = rxByte_r;
  assign rxValid     = rxValid_r;
  assign clkMode3    = mode3_r;
  assign linkIdle    = state_r == ST_IDLE;
  assign linkPaused  = state_r == ST_PAUSED;
  assign dtrReject   = dtrRej_r;
  assign protBits    = prot_r;
  assign protRefused = protRef_r;
  assign colValid    = colValid_r;
  assign colWritable = colWr_r;
  assign pageSel     = page_r;
  assign blockSel    = block_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_pause_tristate;
    state_r == ST_PAUSED |-> laneOe == 4'h0;
  endproperty
  a_pause_tristate: assert property (p_pause_tristate)
    else $error("lanes driven while paused");

  property p_cs_abort;
    state_r == ST_PAUSED && csS |=> state_r == ST_IDLE && rxCnt_r == 3'h0;
  endproperty
  a_cs_abort: assert property (p_cs_abort)
    else $error("deselect in pause did not reset");

  property p_pause_entry;
    state_r == ST_ACTIVE && !csS && !quadEnableBit && !holdLevel && !sclkS
      |=> state_r == ST_PAUSED;
  endproperty
  a_pause_entry: assert property (p_pause_entry)
    else $error("pause not entered");

  property p_pause_exit;
    state_r == ST_PAUSED && !csS && holdLevel && !sclkS
      |=> state_r == ST_ACTIVE;
  endproperty
  a_pause_exit: assert property (p_pause_exit)
    else $error("pause not left");

  property p_qe_no_pause;
    quadEnableBit && state_r != ST_PAUSED |=> state_r != ST_PAUSED;
  endproperty
  a_qe_no_pause: assert property (p_qe_no_pause)
    else $error("pause entered with quad enable");

  property p_pause_freeze;
    state_r == ST_PAUSED && !csS |=> $stable(rxCnt_r) && $stable(txCnt_r);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze)
    else $error("bit position moved in pause");

  property p_dtr_gate;
    laneMode == LANE_X4_DTR && !quadEnableBit |=> dtrReject ##0 !(|laneOe[3:2]);
  endproperty
  a_dtr_gate: assert property (p_dtr_gate)
    else $error("dtr accepted without quad enable");

  property p_prot_lock;
    protWrReq && hwLocked |=> protRefused && $stable(protBits);
  endproperty
  a_prot_lock: assert property (p_prot_lock)
    else $error("locked protect bits changed");

  property p_prot_qe;
    protWrReq && quadEnableBit |=> protBits == $past(protWrData) && !protRefused;
  endproperty
  a_prot_qe: assert property (p_prot_qe)
    else $error("protect pin acted with quad enable");

  property p_col_bound;
    columnAddress > `SNL_COL_LAST |=> !colValid && !colWritable;
  endproperty
  a_col_bound: assert property (p_col_bound)
    else $error("out of bounds column accepted");

  property p_spare_lock;
    eccEnable && columnAddress >= `SNL_SPARE_WR &&
      columnAddress <= `SNL_COL_LAST |=> colValid && !colWritable;
  endproperty
  a_spare_lock: assert property (p_spare_lock)
    else $error("ecc spare half writable");

  property p_rx_rise;
    rxValid |-> $past(sclkRise) && !$past(csS);
  endproperty
  a_rx_rise: assert property (p_rx_rise)
    else $error("byte taken without rising edge");

  property p_idle;
    csS |=> linkIdle ##1 laneOe == 4'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("not idle when deselected");

endmodule : snl_link

//--- snl_pkg.sv
package snl_pkg;

  typedef enum logic [1:0] {
    LANE_X1,
    LANE_X2,
    LANE_X4,
    LANE_X4_DTR
  } snl_lane_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_PAUSED
  } snl_state_t;

endpackage : snl_pkg

//--- snl_sync.sv
`timescale 1ns/1ps
module snl_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = {W{1'h0}}
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // meta_r feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : snl_sync

//--- tb.sv
`timescale 1ns/1ps
module tb
  import snl_pkg::*;
();
  logic        clk, rstB, qe, txEn, lock, pReq, ecc;
  snl_lane_t   lm;
  logic [7:0]  txB, rxByte, got, seed;
  logic [4:0]  pData, protBits;
  logic [11:0] col, blockSel;
  logic [17:0] row;
  logic [5:0]  pageSel;
  logic        csB, sclk, txTake, rxValid, clkMode3, linkIdle;
  logic        linkPaused, dtrReject, protRefused, colValid, colWritable;
  logic [3:0]  hl, p;
  wire  [3:0]  o, oe;
  logic        lk;
  logic [1:0]  wm;
  logic [4:0]  pM;
  int          nTake;
  logic [7:0]  rxQ[$];
  logic [11:0] cT[6] = '{12'h000, 12'h83f, 12'h840, 12'h87f, 12'h880,
                         12'hfff};
  int          err_count, n_checks;

  // device drive wins where enabled, host level elsewhere
  assign p = (oe & o) | (~oe & hl);

  snl_host_model host (.clk(clk), .pin1(p[1]), .csB(csB), .sclk(sclk),
                       .lane(hl));

  snl_link dut (
    .clk(clk), .rst_b(rstB), .csB(csB), .sclk(sclk),
    .ioLane0In(p[0]), .ioLane1In(p[1]), .ioLane2In(p[2]), .ioLane3In(p[3]),
    .ioLane0Out(o[0]), .ioLane1Out(o[1]), .ioLane2Out(o[2]),
    .ioLane3Out(o[3]), .ioLane0Oe(oe[0]), .ioLane1Oe(oe[1]),
    .ioLane2Oe(oe[2]), .ioLane3Oe(oe[3]), .quadEnableBit(qe),
    .laneMode(lm), .txEn(txEn), .txByte(txB), .txTake(txTake),
    .rxByte(rxByte), .rxValid(rxValid), .clkMode3(clkMode3),
    .linkIdle(linkIdle), .linkPaused(linkPaused), .dtrReject(dtrReject),
    .protectBitsLock(lock), .protWrReq(pReq), .protWrData(pData),
    .protBits(protBits), .protRefused(protRefused), .eccEnable(ecc),
    .columnAddress(col), .rowAddress(row), .colValid(colValid),
    .colWritable(colWritable), .pageSel(pageSel), .blockSel(blockSel)
  );

  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nxt

  task automatic chk(input string n, input logic [17:0] s,
                     input logic [17:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic sendRx(input int w);
    seed = nxt(seed);
    rxQ.push_back(seed);
    host.xfer(seed, w, 0, 8 / w - 1, got);
  endtask : sendRx

  task automatic prot(input logic [4:0] d, input logic [4:0] eb,
                      input logic er);
    @(posedge clk);
    pReq  <= 1'h1;
    pData <= d;
    @(posedge clk);
    pReq <= 1'h0;
    @(posedge clk);
    chk("protBits", 18'(protBits), 18'(eb));
    chk("protRefused", 18'(protRefused), 18'(er));
  endtask : prot

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (txTake === 1'h1)
      nTake++;
    if (rxValid === 1'h1) begin
      if (rxQ.size() == 0)
        chk("rxSpare", 18'h1, 18'h0);
      else
        chk("rxByte", 18'(rxByte), 18'(rxQ.pop_front()));
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    rstB = 1'h0; qe = 1'h0; lm = LANE_X1; txEn = 1'h0; txB = 8'h00;
    lock = 1'h0; pReq = 1'h0; pData = 5'h00; ecc = 1'h1; col = 12'h000;
    row = 18'h00000; seed = 8'h27; err_count = 0; n_checks = 0;
    nTake = 0;
    repeat (6) @(posedge clk);
    rstB <= 1'h1;
    repeat (4) @(posedge clk);
    chk("linkIdle", linkIdle, 1);
    chk("oe", oe, 0);
    chk("protBits", protBits, 0);
    host.sel(0);
    chk("clkMode3", clkMode3, 0);
    sendRx(1);
    sendRx(1);
    host.desel(0);
    seed = nxt(seed);
    txB  <= seed;
    txEn <= 1'h1;
    host.sel(1);
    chk("clkMode3", clkMode3, 1);
    host.xfer(8'h00, 1, 0, 7, got);
    chk("txOut", got, seed);
    chk("oe1", oe[1], 1);
    chk("txTake", nTake, 1);
    txEn <= 1'h0;
    host.desel(1);
    lm <= LANE_X2;
    host.sel(0);
    sendRx(2);
    host.desel(0);
    qe <= 1'h1;
    lm <= LANE_X4;
    host.sel(0);
    host.setLane(3, 0);
    chk("paused", linkPaused, 0);
    sendRx(4);
    host.desel(0);
    lm <= LANE_X4_DTR;
    host.cyc(4);
    chk("dtrReject", dtrReject, 0);
    qe <= 1'h0;
    host.setLane(3, 1);
    chk("dtrReject", dtrReject, 1);
    lm <= LANE_X1;
    host.sel(0);
    seed = nxt(seed);
    rxQ.push_back(seed);
    host.xfer(seed, 1, 0, 3, got);
    // pause asked with sclk high, so entry must wait for sclk low
    host.setLane(3, 0);
    chk("paused", linkPaused, 0);
    host.clkTo(0);
    chk("paused", linkPaused, 1);
    host.clkTo(1);
    host.clkTo(0);
    host.setLane(3, 1);
    chk("paused", linkPaused, 0);
    host.xfer(seed, 1, 4, 7, got);
    seed = nxt(seed);
    host.xfer(seed, 1, 0, 2, got);
    host.clkTo(0);
    host.setLane(3, 0);
    host.desel(0);
    chk("linkIdle", linkIdle, 1);
    host.sel(0);
    sendRx(1);
    host.desel(0);
    // pause off, so lane 3 may carry data in x4
    qe <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      seed = nxt(seed);
      wm   = (seed[1:0] == 2'h3) ? 2'h2 : seed[1:0];
      lm  <= snl_lane_t'(wm);
      host.sel(0);
      sendRx(1 << wm);
      host.desel(0);
    end
    // dtr output: one nibble after the fall, the next after the rise
    lm   <= LANE_X4_DTR;
    seed = nxt(seed);
    txB  <= seed;
    txEn <= 1'h1;
    host.sel(0);
    host.clkTo(1);
    host.clkTo(0);
    chk("dtrHi", p, seed[7:4]);
    chk("dtrOe", oe, 4'hf);
    host.clkTo(1);
    chk("dtrLo", p, seed[3:0]);
    chk("txTake", nTake, 2);
    txEn <= 1'h0;
    host.desel(0);
    qe <= 1'h0;
    lock <= 1'h1;
    host.setLane(2, 0);
    prot(5'h15, 5'h00, 1);
    qe <= 1'h1;
    prot(5'h0a, 5'h0a, 0);
    qe <= 1'h0;
    host.setLane(2, 1);
    prot(5'h1f, 5'h1f, 0);
    lock <= 1'h0;
    host.setLane(2, 0);
    prot(5'h11, 5'h11, 0);
    pM = 5'h11;
    for (int k = 0; k < 8; k++) begin
      seed = nxt(seed);
      lk   = seed[7] && !seed[6] && !seed[5];
      lock <= seed[7];
      qe   <= seed[6];
      host.setLane(2, seed[5]);
      if (!lk)
        pM = seed[4:0];
      prot(seed[4:0], pM, lk);
    end
    for (int e = 0; e < 2; e++) begin
      for (int i = 0; i < 6; i++) begin
        @(posedge clk);
        ecc  <= ~e[0];
        col  <= cT[i];
        seed = nxt(seed);
        row  <= {seed[3:0], seed, seed[5:0]};
        repeat (2) @(posedge clk);
        chk("colValid", colValid, i < 4);
        chk("colWritable", colWritable, i < (e ? 4 : 2));
        chk("pageSel", pageSel, row[5:0]);
        chk("blockSel", blockSel, row[17:6]);
      end
    end
    // random columns across the spare area and past its end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      seed = nxt(seed);
      ecc  <= seed[7];
      col  <= {4'h8, seed};
      repeat (2) @(posedge clk);
      chk("colValid", colValid, col < 2176);
      lk = col < 2176 && (!ecc || col < 2112);
      chk("colWritable", colWritable, lk);
    end
    chk("rxLeft", 18'(rxQ.size()), 0);
    finish_test();
  end
endmodule : tb
